// [core/asrx_ctrl.v]
// Receive control, serial capture, receive FIFO and FIFO status of an audio serial controller.
// Assumes an AHB-Lite master with one slave; serial pins come from outside and are synchronised.
//
// Overview of operation
// - Writing one to bit 24 empties the receive FIFO except for a sample pushed in the same cycle; bit reads zero.
// - Flushing never touches the receive shift register or bit counter.
// - Bits 17:16 pick 32, 64 or 128 bit clocks per frame; reset 1.
// - Bits 15:8 divide hclk into bit clock; reset 8.
// - Bits 5:4 pick 8, 16, 20 or 24 bit words; reset 1.
// - Bit 3 high selects mono, left channel only; reset stereo.
// - Bits 2:1 pick I2S, left- or right-justified format; reset I2S.
// - Bit 0 high makes receiver master driving bit clock and select; reset 1.
// - Transmit trigger field bits 19:18 picks threshold; reset almost empty.
// - Receive trigger field bits 17:16 same encoding; reset half full.
// - Bits 9 and 8 show transmit and receive half full.
// - Bits 7 and 6 show transmit almost full and almost empty.
// - Bits 5 and 4 show receive almost full and almost empty.
// - Bits 3 and 2 show transmit full and empty.
// - Bits 1 and 0 show receive full and empty.
// - A sample arriving into a full FIFO raises overrun; FIFO stays intact.
// - Receive trigger is high while occupancy is at or above level.
// - I2S: select low is left; MSB one bit clock after select edge.
// - Justified: select high is left; left starts at edge, right ends there.
//
// Added by the designer: the AHB-Lite register port.
`include "asrx_consts.vh"

module asrx_ctrl (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [4:0] tx_count,
  input wire bit_clk_i,
  output reg bit_clk_o,
  output wire bit_clk_oe_n,
  input wire channel_select_i,
  output reg channel_select_o,
  output wire channel_select_oe_n,
  input wire serial_audio_line_i,
  output reg rx_overrun,
  output reg rx_trigger
);

  reg [1:0] osr_q;
  reg [7:0] div_q;
  reg [1:0] res_q;
  reg mono_q;
  reg [1:0] fmt_q;
  reg master_q;
  reg [1:0] txtrg_q;
  reg [1:0] rxtrg_q;
  reg wr_q;
  reg [7:0] addr_q;
  reg [23:0] mem [0:7];
  reg [`ASRX_AW-1:0] wp_q;
  reg [`ASRX_AW-1:0] rp_q;
  reg [4:0] cnt_q;
  reg [7:0] dcnt_q;
  reg [6:0] bclk_q;
  reg [2:0] ck_s;
  reg [2:0] cs_s;
  reg [1:0] dat_s;
  reg prev_cs_q;
  reg [23:0] sh_q;
  reg [5:0] bit_q;
  reg [23:0] word_q;
  reg push_q;

  wire acc = hsel & hready & htrans[1];
  wire wr_ok = wr_q & (addr_q == `ASRX_OFF_RXCTL);
  wire fs_ok = wr_q & (addr_q == `ASRX_OFF_FSTS);
  wire flush = wr_ok & hwdata[`ASRX_FLUSH_BIT];
  wire rd_pop = acc & ~hwrite & (haddr[7:0] == `ASRX_OFF_RXDATA) & (cnt_q != 5'h00);
  wire full = (cnt_q == `ASRX_DEPTH);
  wire empty = (cnt_q == 5'h00);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bit_clk_oe_n = ~master_q;
  assign channel_select_oe_n = ~master_q;

  // Register bus: address phase captured, write data taken in data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q <= acc & hwrite;
      addr_q <= haddr[7:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osr_q <= `ASRX_RST_OSR;
      div_q <= `ASRX_RST_DIV;
      res_q <= `ASRX_RST_RES;
      mono_q <= `ASRX_RST_MONO;
      fmt_q <= `ASRX_RST_FMT;
      master_q <= `ASRX_RST_MASTER;
      txtrg_q <= `ASRX_RST_TXTRG;
      rxtrg_q <= `ASRX_RST_RXTRG;
    end else begin
      if (wr_ok) begin
        osr_q <= hwdata[`ASRX_OSR_LSB+1:`ASRX_OSR_LSB];
        div_q <= hwdata[`ASRX_DIV_LSB+7:`ASRX_DIV_LSB];
        res_q <= hwdata[`ASRX_RES_LSB+1:`ASRX_RES_LSB];
        mono_q <= hwdata[`ASRX_MONO_BIT];
        fmt_q <= hwdata[`ASRX_FMT_LSB+1:`ASRX_FMT_LSB];
        master_q <= hwdata[`ASRX_MASTER_BIT];
      end
      if (fs_ok) begin
        txtrg_q <= hwdata[`ASRX_TXTRG_LSB+1:`ASRX_TXTRG_LSB];
        rxtrg_q <= hwdata[`ASRX_RXTRG_LSB+1:`ASRX_RXTRG_LSB];
      end
    end
  end

  // Threshold flags, shared by both FIFOs
  function [4:0] flags;
    input [4:0] c;
    begin
      flags = {c >= `ASRX_HF_LVL, c >= `ASRX_AF_LVL, c <= `ASRX_AE_LVL,
               c == `ASRX_DEPTH, c == 5'h00};
    end
  endfunction

  function [4:0] level;
    input [1:0] sel;
    begin
      case (sel)
        `ASRX_TRG_AE: level = `ASRX_AE_LVL;
        `ASRX_TRG_HF: level = `ASRX_HF_LVL;
        `ASRX_TRG_AF: level = `ASRX_AF_LVL;
        default: level = 5'h1f;
      endcase
    end
  endfunction

  wire [4:0] rxf = flags(cnt_q);
  wire [4:0] txf = flags(tx_count);

  // Read data is prepared in the address phase and held through the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc & ~hwrite) begin
      case (haddr[7:0])
        `ASRX_OFF_RXDATA: hrdata <= empty ? 32'h0000_0000 : {8'h00, mem[rp_q]};
        `ASRX_OFF_RXCTL: hrdata <= {14'h0000, osr_q, div_q, 2'b00, res_q, mono_q, fmt_q, master_q};
        `ASRX_OFF_FSTS: hrdata <= {12'h000, txtrg_q, rxtrg_q, 6'h00, txf[4], rxf[4],
                                   txf[3], txf[2], rxf[3], rxf[2], txf[1], txf[0], rxf[1], rxf[0]};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Receive FIFO; a flush resets pointers while a same-cycle sample is still kept
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= {`ASRX_AW{1'b0}};
      rp_q <= {`ASRX_AW{1'b0}};
      cnt_q <= 5'h00;
    end else if (flush) begin
      rp_q <= {`ASRX_AW{1'b0}};
      wp_q <= {{(`ASRX_AW-1){1'b0}}, push_q};
      cnt_q <= {4'h0, push_q};
    end else begin
      if (push_q & ~full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (rd_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if ((push_q & ~full) & ~rd_pop) begin
        cnt_q <= cnt_q + 5'h01;
      end else if (~(push_q & ~full) & rd_pop) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  always @(posedge hclk) begin
    if (push_q & (flush | ~full)) begin
      mem[flush ? {`ASRX_AW{1'b0}} : wp_q] <= word_q;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_overrun <= 1'b0;
      rx_trigger <= 1'b0;
    end else begin
      rx_overrun <= (push_q & full & ~flush) | (rx_overrun & ~flush);
      rx_trigger <= cnt_q >= level(rxtrg_q);
    end
  end

  // Master clocking: bit clock toggles every div_q cycles, select every half frame
  wire [6:0] half = (osr_q == 2'h0) ? 7'd15 : (osr_q == 2'h2) ? 7'd63 : 7'd31;
  wire div_tick = (dcnt_q == 8'h01) | (dcnt_q == 8'h00);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dcnt_q <= `ASRX_RST_DIV;
      bit_clk_o <= 1'b0;
      channel_select_o <= 1'b0;
      bclk_q <= 7'h00;
    end else if (!master_q) begin
      dcnt_q <= div_q;
      bit_clk_o <= 1'b0;
      bclk_q <= 7'h00;
    end else if (div_tick) begin
      dcnt_q <= div_q;
      bit_clk_o <= ~bit_clk_o;
      if (bit_clk_o) begin
        bclk_q <= (bclk_q == half) ? 7'h00 : bclk_q + 7'h01;
        if (bclk_q == half) begin
          channel_select_o <= ~channel_select_o;
        end
      end
    end else begin
      dcnt_q <= dcnt_q - 8'h01;
    end
  end

  // Pin synchronisers; only stage 1 and later feed logic
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_s <= 3'b000;
      cs_s <= 3'b000;
      dat_s <= 2'b00;
    end else begin
      ck_s <= {ck_s[1:0], bit_clk_i};
      cs_s <= {cs_s[1:0], channel_select_i};
      dat_s <= {dat_s[0], serial_audio_line_i};
    end
  end

  wire rise = master_q ? (div_tick & ~bit_clk_o) : (ck_s[1] & ~ck_s[2]);
  wire cs_now = master_q ? channel_select_o : cs_s[1];
  wire cs_edge = cs_now ^ prev_cs_q;
  wire [5:0] res_bits = (res_q == 2'h0) ? 6'd8 : (res_q == 2'h1) ? 6'd16 :
                        (res_q == 2'h2) ? 6'd20 : 6'd24;
  wire [23:0] mask = ~(24'hff_ffff << res_bits);
  wire [23:0] sh_n = {sh_q[22:0], dat_s[1]};
  wire [5:0] pos = cs_edge ? 6'd0 : bit_q;
  wire i2s_done = (fmt_q == `ASRX_FMT_I2S) & (pos == res_bits);
  wire lj_done = (fmt_q == `ASRX_FMT_LJ) & (pos == res_bits - 6'd1);
  wire rj_done = (fmt_q == `ASRX_FMT_RJ) & cs_edge;
  wire left_cur = (fmt_q == `ASRX_FMT_I2S) ? ~cs_now : cs_now;
  wire is_left = rj_done ? prev_cs_q : left_cur;

  // Shift register runs regardless of FIFO state or flushes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_cs_q <= 1'b0;
      sh_q <= 24'h00_0000;
      bit_q <= 6'h00;
      word_q <= 24'h00_0000;
      push_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      if (rise) begin
        prev_cs_q <= cs_now;
        sh_q <= sh_n;
        bit_q <= (pos == 6'h3f) ? pos : pos + 6'd1;
        if (rj_done) begin
          word_q <= sh_q & mask;
          push_q <= ~mono_q | is_left;
        end else if (i2s_done | lj_done) begin
          word_q <= sh_n & mask;
          push_q <= ~mono_q | is_left;
        end
      end
    end
  end

endmodule // asrx_ctrl

// [dv/asrx_codec.sv]
// Behavioural audio transmitter that follows the receiver's bit clock and channel select.
// Assumes 16-bit words and a link driven by the receiver as master.
module asrx_codec #(
  parameter [15:0] LEFT_WORD = 16'ha5c3,
  parameter [15:0] RIGHT_WORD = 16'h3c5a
) (
  input wire bit_clk,
  input wire channel_select,
  input wire left_on_high,
  output reg serial_audio_line
);
  timeunit 1ns;
  timeprecision 1ps;
  reg sel_q = 1'b0;
  reg [15:0] sh_q = 16'h0000;
  reg [15:0] word;
  initial serial_audio_line = 1'b0;
  // Data moves on the falling edge; spent bits shift out inverted so the line never holds
  always @(negedge bit_clk) begin
    // Let select settle; it changes in the same time step as the clock
    #1;
    sel_q <= channel_select;
    word = (channel_select ^ left_on_high) ? RIGHT_WORD : LEFT_WORD;
    if (channel_select != sel_q && left_on_high) begin
      serial_audio_line <= word[15];
      sh_q <= {word[14:0], ~word[15]};
    end else if (channel_select != sel_q) begin
      serial_audio_line <= ~serial_audio_line;
      sh_q <= word;
    end else begin
      serial_audio_line <= sh_q[15];
      sh_q <= {sh_q[14:0], ~sh_q[15]};
    end
  end
endmodule // asrx_codec

// [dv/asrx_ctrl_chk.sv]
// Assertions on the receive controller's ports.
// Assumes one AHB-Lite master issuing word accesses.
module asrx_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire [4:0] tx_count,
  input wire bit_clk_o,
  input wire bit_clk_oe_n,
  input wire channel_select_oe_n,
  input wire rx_overrun,
  input wire rx_trigger
);
  reg ph_q, wr_q, role_q;
  reg [7:0] adr_q;
  wire ctl_wr = ph_q && wr_q && adr_q == 8'h10;
  wire flush = ctl_wr && hwdata[24];
  wire rd = ph_q && !wr_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      role_q <= 1'b1;
    end else begin
      ph_q <= hsel && hready && htrans[1];
      wr_q <= hwrite;
      adr_q <= haddr[7:0];
      if (ctl_wr) role_q <= hwdata[0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_role_drive: assert property (bit_clk_oe_n == !role_q && channel_select_oe_n == !role_q)
    else $error("link drive differs from role");
  a_slave_clk: assert property (bit_clk_oe_n |=> !bit_clk_o) else $error("bit clock out in slave");
  a_flush_ovr: assert property (flush |=> !rx_overrun) else $error("overrun kept over flush");
  a_flush_trig: assert property (flush |-> ##[1:3] !rx_trigger) else $error("trigger kept over flush");
  a_ovr_sticky: assert property (rx_overrun && !flush |=> rx_overrun) else $error("overrun lost");
  a_ctl_zero: assert property (rd && adr_q == 8'h10 |-> hrdata[31:18] == 14'h0) else $error("flush bit read");
  a_tx_flags: assert property (rd && adr_q == 8'h14 |->
    hrdata[3:2] == {$past(tx_count) == 5'h08, $past(tx_count) == 5'h00}) else $error("tx full or empty");
  a_rx_flags: assert property (rd && adr_q == 8'h14 && hrdata[1] |->
    hrdata[5] && hrdata[8] && !hrdata[4] && !hrdata[0]) else $error("rx flags inconsistent");
  c_flush: cover property (flush);
  c_ovr: cover property ($rose(rx_overrun));
  c_trig: cover property ($rose(rx_trigger));
endmodule // asrx_chk
bind asrx_ctrl asrx_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .tx_count(tx_count), .bit_clk_o(bit_clk_o),
  .bit_clk_oe_n(bit_clk_oe_n), .channel_select_oe_n(channel_select_oe_n), .rx_overrun(rx_overrun),
  .rx_trigger(rx_trigger));

// [dv/tb_asrx_ctrl.sv]
// Self-checking bench for the receive controller with a behavioural transmitter.
// Assumes the controller starts as link master; bus is a single AHB-Lite master.
module tb_asrx_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] LW = 32'h0000_a5c3;
  localparam [31:0] RW = 32'h0000_3c5a;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [4:0] txc; logic [31:0] exp;} asrx_row_t;
  asrx_row_t rows [10] = '{'{1'b0, 8'h10, 32'h0, 5'h0, 32'h0001_0811}, '{1'b0, 8'h14, 32'h0, 5'h0, 32'h0001_0055},
    '{1'b0, 8'h1c, 32'h0, 5'h0, 32'h0}, '{1'b0, 8'h08, 32'h0, 5'h0, 32'h0},
    '{1'b1, 8'h14, 32'h000e_03ff, 5'h0, 32'h000e_0055}, '{1'b1, 8'h14, 32'h0001_0000, 5'h8, 32'h0001_0299},
    '{1'b0, 8'h14, 32'h0, 5'h4, 32'h0001_0211}, '{1'b0, 8'h14, 32'h0, 5'h6, 32'h0001_0291},
    '{1'b0, 8'h14, 32'h0, 5'h2, 32'h0001_0051}, '{1'b1, 8'h10, 32'h0101_0411, 5'h0, 32'h0001_0411}};
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, lj = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd, w0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [4:0] tx_count = 5'h0;
  wire hready, hresp, bclk_o, bclk_oe_n, cs_o, cs_oe_n, sal, ovr, trig;
  wire [31:0] hrdata;
  wire bclk = bclk_oe_n ? 1'b0 : bclk_o;
  wire cs = cs_oe_n ? 1'b0 : cs_o;
  integer n_errors = 0, n_tests = 0, i;
  always #2.5 hclk = ~hclk;
  asrx_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .tx_count(tx_count), .bit_clk_i(bclk), .bit_clk_o(bclk_o), .bit_clk_oe_n(bclk_oe_n), .channel_select_i(cs),
    .channel_select_o(cs_o), .channel_select_oe_n(cs_oe_n), .serial_audio_line_i(sal), .rx_overrun(ovr),
    .rx_trigger(trig));
  asrx_codec i_codec (.bit_clk(bclk), .channel_select(cs), .left_on_high(lj), .serial_audio_line(sal));
  task chk(input string name, input [31:0] exp, input [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task fill;
    rd = 32'h0;
    for (i = 0; i < 2000 && rd[1] !== 1'b1; i++) xfer(1'b0, 8'h14, 32'h0);
  endtask
  task test_done;
    $display("Checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge hclk);
    n_errors++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[k]) begin
      tx_count <= rows[k].txc;
      if (rows[k].wr) xfer(1'b1, rows[k].a, rows[k].d);
      xfer(1'b0, rows[k].a, 32'h0);
      chk("reg_read", rows[k].exp, rd);
    end
    // Flush between words: the next word must still arrive whole
    repeat (700) @(posedge hclk);
    xfer(1'b1, 8'h10, 32'h0101_0411);
    fill;
    chk("status_full", 32'h0001_0166, rd);
    chk("rx_trigger", 32'h1, {31'h0, trig});
    for (i = 0; i < 600 && ovr !== 1'b1; i++) @(posedge hclk);
    chk("rx_overrun", 32'h1, {31'h0, ovr});
    xfer(1'b0, 8'h08, 32'h0);
    w0 = rd;
    chk("rx_word0", (w0 === RW) ? RW : LW, w0);
    xfer(1'b0, 8'h08, 32'h0);
    chk("rx_word1", (w0 === RW) ? LW : RW, rd);
    xfer(1'b1, 8'h10, 32'h0101_0411);
    xfer(1'b0, 8'h14, 32'h0);
    chk("status_flushed", 32'h0001_0055, rd);
    chk("overrun_flushed", 32'h0, {31'h0, ovr});
    chk("trigger_flushed", 32'h0, {31'h0, trig});
    lj <= 1'b1;
    xfer(1'b1, 8'h10, 32'h0001_041b);
    repeat (600) @(posedge hclk);
    xfer(1'b1, 8'h10, 32'h0101_041b);
    fill;
    for (i = 0; i < 8; i++) begin
      xfer(1'b0, 8'h08, 32'h0);
      chk("mono_word", LW, rd);
    end
    // Slave role: link pins released, generated clock parked low
    xfer(1'b1, 8'h10, 32'h0001_0410);
    repeat (40) @(posedge hclk);
    chk("bclk_oe_n", 32'h1, {31'h0, bclk_oe_n});
    chk("cs_oe_n", 32'h1, {31'h0, cs_oe_n});
    chk("bclk_slave", 32'h0, {31'h0, bclk_o});
    chk("hresp", 32'h0, {31'h0, hresp});
    test_done;
  end
endmodule // tb_asrx_ctrl

// [shared/asrx_consts.vh]
// Constants of the audio serial receive controller.
// Assumes inclusion by bare name from the core file.
`ifndef ASRX_CONSTS_VH
`define ASRX_CONSTS_VH
`define ASRX_OFF_RXDATA 8'h08
`define ASRX_OFF_RXCTL 8'h10
`define ASRX_OFF_FSTS 8'h14
`define ASRX_FLUSH_BIT 24
`define ASRX_OSR_LSB 16
`define ASRX_DIV_LSB 8
`define ASRX_RES_LSB 4
`define ASRX_MONO_BIT 3
`define ASRX_FMT_LSB 1
`define ASRX_MASTER_BIT 0
`define ASRX_TXTRG_LSB 18
`define ASRX_RXTRG_LSB 16
`define ASRX_RST_OSR 2'h1
`define ASRX_RST_DIV 8'h08
`define ASRX_RST_RES 2'h1
`define ASRX_RST_MONO 1'b0
`define ASRX_RST_FMT 2'h0
`define ASRX_RST_MASTER 1'b1
`define ASRX_RST_TXTRG 2'h0
`define ASRX_RST_RXTRG 2'h1
`define ASRX_FMT_I2S 2'h0
`define ASRX_FMT_LJ 2'h1
`define ASRX_FMT_RJ 2'h2
`define ASRX_TRG_AE 2'h0
`define ASRX_TRG_HF 2'h1
`define ASRX_TRG_AF 2'h2
`define ASRX_DEPTH 5'h08
`define ASRX_AW 3
`define ASRX_AE_LVL 5'h02
`define ASRX_HF_LVL 5'h04
`define ASRX_AF_LVL 5'h06
`endif
